// ---- inc/clk_fail_pkg.sv ----
package clk_fail_pkg;

	// Register word offsets on the local port
	localparam logic [3:0] OFF_CTRL   = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_MASK   = 4'h8;
	localparam logic [3:0] OFF_STATE  = 4'hC;

	// Control word fields
	localparam int CTRL_LF_IRQ  = 0;
	localparam int CTRL_LF_AUTO = 1;
	localparam int CTRL_HF_IRQ  = 2;
	localparam int CTRL_HF_AUTO = 3;
	localparam int CTRL_SEL_LO  = 4;
	localparam int CTRL_SEL_HI  = 5;
	localparam int CTRL_HFX16   = 6;
	localparam int CTRL_LF_XTAL = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// Status and mask bits, one per watched source
	localparam int EVT_W   = 4;
	localparam int EVT_LF  = 0;
	localparam int EVT_HFX = 1;
	localparam int EVT_PIN = 2;
	localparam int EVT_PLL = 3;
	localparam logic [3:0] MASK_RST = 4'h0;

	// Failure windows, in reference oscillator rising edges
	localparam logic [3:0] LF_WIN_REF = 4'h4;
	localparam logic [3:0] HF_WIN_REF = 4'h8;

	// Supported system clock rates
	localparam int HIGH_FREQ_INTERNAL_OSC_MHZ      = 26;
	localparam int HIGH_FREQ_CRYSTAL_CLOCK_MHZ_HI  = 26;
	localparam int HIGH_FREQ_CRYSTAL_CLOCK_MHZ_LO  = 16;

	typedef enum logic [1:0] {
		SRC_HIGH_FREQ_INTERNAL_OSC  = 2'b00,
		SRC_HIGH_FREQ_CRYSTAL_CLOCK = 2'b01,
		SRC_PIN    = 2'b10,
		SRC_PLL    = 2'b11
	} sys_src_t;

	typedef enum logic [1:0] {
		PWR_ACTIVE    = 2'b00,
		PWR_FLEXI     = 2'b01,
		PWR_HIBERNATE = 2'b10,
		PWR_SHUTDOWN  = 2'b11
	} pwr_mode_t;

endpackage : clk_fail_pkg

// ---- hw/clk_watch.sv ----
`timescale 1ns/100ps
`default_nettype none
module clk_watch
	import clk_fail_pkg::*;
#(
	parameter logic [3:0] WIN = 4'h4
) (
	input  wire logic i_mclk,
	input  wire logic i_nrst,
	input  wire logic i_en,
	input  wire logic i_ref_lvl,
	input  wire logic i_watch_lvl,
	output logic      o_fail
);

	logic       ref_d_r;
	logic       watch_d_r;
	logic [3:0] cnt_r;
	logic       ref_rise;
	logic       watch_edge;

	assign ref_rise   = i_ref_lvl & ~ref_d_r;
	assign watch_edge = i_watch_lvl ^ watch_d_r;

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			ref_d_r   <= 1'b0;
			watch_d_r <= 1'b0;
		end else begin
			ref_d_r   <= i_ref_lvl;
			watch_d_r <= i_watch_lvl;
		end
	end

	// Counter saturates so a dead clock keeps the flag up
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_r  <= 4'h0;
			o_fail <= 1'b0;
		end else if (!i_en || watch_edge) begin
			cnt_r  <= 4'h0;
			o_fail <= 1'b0;
		end else if (ref_rise && cnt_r != WIN) begin
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r == WIN - 4'h1) begin
				o_fail <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	sequence last_ref_s;
		i_en && !watch_edge && ref_rise && cnt_r == WIN - 4'h1;
	endsequence

	window_fail_a: assert property (last_ref_s |=> o_fail)
		else $error("watch window expired without failure");
	edge_clears_a: assert property (watch_edge |=> !o_fail && cnt_r == 4'h0)
		else $error("watched edge did not clear failure");
	disable_clr_a: assert property (!i_en |=> !o_fail)
		else $error("disabled monitor shows failure");

endmodule : clk_watch
`default_nettype wire

// ---- hw/evt_status.sv ----
`timescale 1ns/100ps
`default_nettype none
module evt_status
	import clk_fail_pkg::*;
(
	input  wire logic             i_mclk,
	input  wire logic             i_nrst,
	input  wire logic [EVT_W-1:0] i_set,
	input  wire logic             i_rd_clr,
	input  wire logic             i_mask_wr,
	input  wire logic [EVT_W-1:0] i_mask_data,
	output logic      [EVT_W-1:0] o_status,
	output logic      [EVT_W-1:0] o_mask,
	output logic                  o_irq
);

	logic [EVT_W-1:0] status_nxt;
	logic [EVT_W-1:0] mask_nxt;

	// A set landing on the clearing read survives it
	assign status_nxt = (i_rd_clr ? {EVT_W{1'b0}} : o_status) | i_set;
	assign mask_nxt   = i_mask_wr ? i_mask_data : o_mask;

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_status <= {EVT_W{1'b0}};
		end else begin
			o_status <= status_nxt;
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_mask <= MASK_RST;
		end else begin
			o_mask <= mask_nxt;
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(status_nxt & mask_nxt);
		end
	end

endmodule : evt_status
`default_nettype wire

// ---- hw/clock_fail_monitor.sv ----
// What this block does
// - Internal slow oscillator watches slow crystal in every mode but shutdown
// - Slow crystal stop optionally raises an interrupt
// - Optional automatic switch to internal slow oscillator
// - Internal fast oscillator watches crystal, pin, PLL
// - Selected fast source stopping reports an interrupt
// - Optional automatic fallback to internal fast oscillator
// - Fast crystal runs at 26 or 16 MHz
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module clock_fail_monitor
	import clk_fail_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_nrst,
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic             o_irq,
	input  wire logic [1:0]  i_pwr_mode,
	input  wire logic        i_low_freq_internal_osc,
	input  wire logic        i_low_freq_crystal_clock,
	input  wire logic        i_high_freq_internal_osc,
	input  wire logic        i_high_freq_crystal_clock,
	input  wire logic        i_external_pin_clock_input,
	input  wire logic        i_pll_clock,
	output logic             o_lf_src_int,
	output sys_src_t         o_sys_src,
	output logic             o_high_freq_crystal_clock_16m
);

	function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
		hit = (addr == off);
	endfunction : hit

	function automatic sys_src_t src_of(input int idx);
		case (idx)
			0:       src_of = SRC_HIGH_FREQ_CRYSTAL_CLOCK;
			1:       src_of = SRC_PIN;
			default: src_of = SRC_PLL;
		endcase
	endfunction : src_of

	logic [7:0]       ctrl_r;
	logic [31:0]      rdata_nxt;
	logic             ctrl_wr;
	logic             status_rd;
	logic             mask_wr;
	logic             mon_on;
	logic             lf_fail;
	logic             lf_fail_d_r;
	logic             lf_evt;
	logic [2:0]       hf_en;
	logic [2:0]       hf_fail;
	logic [2:0]       hf_fail_d_r;
	logic [2:0]       hf_evt;
	logic             hf_any_evt;
	logic [2:0]       hf_watch;
	logic [EVT_W-1:0] evt_set;
	logic [EVT_W-1:0] status;
	logic [EVT_W-1:0] mask;
	logic             irq_w;
	sys_src_t         src_req;

	assign ctrl_wr   = i_wr & hit(i_addr, OFF_CTRL);
	assign mask_wr   = i_wr & hit(i_addr, OFF_MASK);
	assign status_rd = i_rd & hit(i_addr, OFF_STATUS);
	assign src_req   = sys_src_t'(i_wdata[CTRL_SEL_HI:CTRL_SEL_LO]);

	// Only shutdown stops the watchers; every other mode keeps them running
	assign mon_on = (pwr_mode_t'(i_pwr_mode) != PWR_SHUTDOWN);

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_r <= CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_r <= i_wdata[7:0];
		end
	end

	// Slow crystal watcher, referenced to the internal slow oscillator
	clk_watch #(
		.WIN         (LF_WIN_REF)
	) u_lf_watch (
		.i_mclk      (i_mclk),
		.i_nrst      (i_nrst),
		.i_en        (mon_on),
		.i_ref_lvl   (i_low_freq_internal_osc),
		.i_watch_lvl (i_low_freq_crystal_clock),
		.o_fail      (lf_fail)
	);

	// Fast watchers only arm for the source actually driving the system
	assign hf_watch = {i_pll_clock, i_external_pin_clock_input, i_high_freq_crystal_clock};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_hf
			assign hf_en[gi] = mon_on & (o_sys_src == src_of(gi));
			clk_watch #(
				.WIN         (HF_WIN_REF)
			) u_hf_watch (
				.i_mclk      (i_mclk),
				.i_nrst      (i_nrst),
				.i_en        (hf_en[gi]),
				.i_ref_lvl   (i_high_freq_internal_osc),
				.i_watch_lvl (hf_watch[gi]),
				.o_fail      (hf_fail[gi])
			);
		end
	endgenerate

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			lf_fail_d_r <= 1'b0;
			hf_fail_d_r <= 3'h0;
		end else begin
			lf_fail_d_r <= lf_fail;
			hf_fail_d_r <= hf_fail;
		end
	end

	assign lf_evt     = lf_fail & ~lf_fail_d_r;
	assign hf_evt     = hf_fail & ~hf_fail_d_r;
	assign hf_any_evt = |hf_evt;

	// Detection enables gate what reaches the sticky flags
	always_comb begin
		evt_set          = {EVT_W{1'b0}};
		evt_set[EVT_LF]  = lf_evt & ctrl_r[CTRL_LF_IRQ];
		evt_set[EVT_HFX] = hf_evt[0] & ctrl_r[CTRL_HF_IRQ];
		evt_set[EVT_PIN] = hf_evt[1] & ctrl_r[CTRL_HF_IRQ];
		evt_set[EVT_PLL] = hf_evt[2] & ctrl_r[CTRL_HF_IRQ];
	end

	evt_status u_status (
		.i_mclk      (i_mclk),
		.i_nrst      (i_nrst),
		.i_set       (evt_set),
		.i_rd_clr    (status_rd),
		.i_mask_wr   (mask_wr),
		.i_mask_data (i_wdata[EVT_W-1:0]),
		.o_status    (status),
		.o_mask      (mask),
		.o_irq       (irq_w)
	);

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= irq_w;
		end
	end

	// Boot runs on the internal slow oscillator until software picks the crystal.
	// A failover wins over a write in the same cycle so that write cannot reselect the failing crystal.
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_lf_src_int <= 1'b1;
		end else if (lf_evt && ctrl_r[CTRL_LF_AUTO]) begin
			o_lf_src_int <= 1'b1;
		end else if (ctrl_wr) begin
			o_lf_src_int <= ~i_wdata[CTRL_LF_XTAL];
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_sys_src <= SRC_HIGH_FREQ_INTERNAL_OSC;
		end else if (hf_any_evt && ctrl_r[CTRL_HF_AUTO]) begin
			o_sys_src <= SRC_HIGH_FREQ_INTERNAL_OSC;
		end else if (ctrl_wr) begin
			o_sys_src <= src_req;
		end
	end

	// Crystal rate select; only the two supported rates exist
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_high_freq_crystal_clock_16m <= 1'b0;
		end else if (ctrl_wr) begin
			o_high_freq_crystal_clock_16m <= i_wdata[CTRL_HFX16];
		end
	end

	always_comb begin
		rdata_nxt = 32'h0;
		if (i_rd) begin
			case (i_addr)
				OFF_CTRL:   rdata_nxt[7:0] = ctrl_r;
				OFF_STATUS: rdata_nxt[EVT_W-1:0] = status;
				OFF_MASK:   rdata_nxt[EVT_W-1:0] = mask;
				OFF_STATE:  rdata_nxt[7:0] = {lf_fail, hf_fail, o_high_freq_crystal_clock_16m,
						o_sys_src, o_lf_src_int};
				default:    rdata_nxt = 32'h0;
			endcase
		end
	end

	// Data stand only in the cycle after the read
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 32'h0;
		end else begin
			o_rdata <= rdata_nxt;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	sequence lf_stop_s;
		lf_evt && ctrl_r[CTRL_LF_AUTO];
	endsequence

	sequence hf_stop_s;
		hf_any_evt && ctrl_r[CTRL_HF_AUTO];
	endsequence

	lf_failover_a: assert property (lf_stop_s |=> o_lf_src_int)
		else $error("slow clock did not fail over");
	lf_no_auto_a: assert property (lf_evt && !ctrl_r[CTRL_LF_AUTO] && !ctrl_wr
			|=> $stable(o_lf_src_int))
		else $error("slow clock switched without failover enabled");
	hf_failover_a: assert property (hf_stop_s |=> o_sys_src == SRC_HIGH_FREQ_INTERNAL_OSC)
		else $error("system clock did not fall back");
	hf_no_auto_a: assert property (hf_any_evt && !ctrl_r[CTRL_HF_AUTO] && !ctrl_wr
			|=> $stable(o_sys_src))
		else $error("system clock switched without failover enabled");
	lf_flag_set_a: assert property (lf_evt && ctrl_r[CTRL_LF_IRQ] |=> status[EVT_LF])
		else $error("slow clock failure not flagged");
	lf_flag_gate_a: assert property (lf_evt && !ctrl_r[CTRL_LF_IRQ]
			|=> !$rose(status[EVT_LF]))
		else $error("slow clock flagged while detection off");
	hf_flag_set_a: assert property (hf_evt[0] && ctrl_r[CTRL_HF_IRQ]
			|=> status[EVT_HFX])
		else $error("crystal failure not flagged");
	hf_idle_src_a: assert property (o_sys_src == SRC_HIGH_FREQ_INTERNAL_OSC |-> hf_en == 3'h0)
		else $error("fast watcher armed on internal oscillator");
	flag_hold_a: assert property (status[EVT_LF] && !status_rd
			|=> status[EVT_LF])
		else $error("sticky flag dropped without a read");
	irq_level_a: assert property (status_rd && evt_set == 4'h0
			|=> ##1 !o_irq)
		else $error("interrupt stayed after clearing read");
	read_data_a: assert property (status_rd |=> o_rdata[EVT_W-1:0] == $past(status))
		else $error("status read returned wrong data");
	read_gap_a: assert property (!i_rd |=> o_rdata == 32'h0)
		else $error("read data outside the read slot");
	shutdown_a: assert property (i_pwr_mode == PWR_SHUTDOWN |=> !lf_fail)
		else $error("watcher active in shutdown");

endmodule : clock_fail_monitor
`default_nettype wire

// ---- dv/osc_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module osc_model (
	input  wire logic       i_mclk,
	input  wire logic       i_nrst,
	input  wire logic       i_lf_stop,
	input  wire logic [2:0] i_hf_stop,
	output logic            o_lf_ref,
	output logic            o_lf_xtal,
	output logic            o_hf_ref,
	output logic            o_hfx,
	output logic            o_pin,
	output logic            o_pll
);
	logic [1:0] div_r;

	// A stopped source holds its last level, as a dead oscillator does
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			div_r     <= 2'h0;
			o_lf_ref  <= 1'b0;
			o_lf_xtal <= 1'b0;
			o_hf_ref  <= 1'b0;
			o_hfx     <= 1'b0;
			o_pin     <= 1'b0;
			o_pll     <= 1'b0;
		end else begin
			div_r    <= div_r + 2'h1;
			o_hf_ref <= ~o_hf_ref;
			if (div_r[0])
				o_lf_ref <= ~o_lf_ref;
			// Crystal edges fall between reference edges on purpose
			if (!div_r[0] && !i_lf_stop)
				o_lf_xtal <= ~o_lf_xtal;
			if (!i_hf_stop[0])
				o_hfx <= ~o_hfx;
			if (!i_hf_stop[1])
				o_pin <= ~o_pin;
			// Slow answer: the loop clock toggles only every other cycle
			if (div_r[0] && !i_hf_stop[2])
				o_pll <= ~o_pll;
		end
	end
endmodule : osc_model
`default_nettype wire

// ---- dv/clock_fail_monitor_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module clock_fail_monitor_tb
	import clk_fail_pkg::*;
;
	logic        i_mclk, i_nrst, i_wr, i_rd, lf_stop, o_irq, o_lf_src_int, o_high_freq_crystal_clock_16m;
	logic        lf_ref, lf_xtal, hf_ref, hfx, pin, pll;
	logic [3:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, rd_val;
	logic [1:0]  i_pwr_mode;
	logic [2:0]  hf_stop;
	sys_src_t    o_sys_src;
	int          failures, check_count, cycles;

	clock_fail_monitor clock_fail_monitor_i (.i_mclk(i_mclk), .i_nrst(i_nrst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_irq(o_irq), .i_pwr_mode(i_pwr_mode), .i_low_freq_internal_osc(lf_ref),
		.i_low_freq_crystal_clock(lf_xtal), .i_high_freq_internal_osc(hf_ref),
		.i_high_freq_crystal_clock(hfx), .i_external_pin_clock_input(pin),
		.i_pll_clock(pll), .o_lf_src_int(o_lf_src_int), .o_sys_src(o_sys_src),
		.o_high_freq_crystal_clock_16m(o_high_freq_crystal_clock_16m));
	osc_model osc_model_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_lf_stop(lf_stop),
		.i_hf_stop(hf_stop), .o_lf_ref(lf_ref), .o_lf_xtal(lf_xtal), .o_hf_ref(hf_ref),
		.o_hfx(hfx), .o_pin(pin), .o_pll(pll));

	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	task give_verdict;
		$display("failures %0d checks %0d", failures, check_count);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	// Whole run is about 260 cycles
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			give_verdict();
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Tasks drive on a rising edge and return at the falling edge, where outputs are settled
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_mclk);
		i_wr    <= 1'b0;
		@(negedge i_mclk);
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_mclk);
		i_rd   <= 1'b0;
		@(negedge i_mclk);
		rd_val = o_rdata;
	endtask : rd

	task wait_irq;
		int n;
		n = 0;
		while (o_irq !== 1'b1 && n < 200) begin
			@(negedge i_mclk);
			n++;
		end
	endtask : wait_irq

	task t_reset;
		rd(OFF_CTRL);
		chk(rd_val, 32'h0);
		rd(OFF_MASK);
		chk(rd_val, 32'h0);
		wr(4'h6, 32'hFFFF_FFFF);
		rd(OFF_STATE);
		chk(rd_val, 32'h1);
		rd(4'h2);
		chk(rd_val, 32'h0);
		chk(o_irq, 1'b0);
	endtask : t_reset

	task t_lf_auto;
		@(posedge i_mclk);
		i_pwr_mode <= 2'h2;
		wr(OFF_CTRL, 32'h83);
		wr(OFF_MASK, 32'h1);
		chk(o_lf_src_int, 1'b0);
		lf_stop <= 1'b1;
		wait_irq();
		chk(o_irq, 1'b1);
		chk(o_lf_src_int, 1'b1);
		rd(OFF_STATUS);
		chk(rd_val, 32'h1);
		rd(OFF_STATUS);
		chk(rd_val, 32'h0);
		chk(o_irq, 1'b0);
		lf_stop    <= 1'b0;
		@(posedge i_mclk);
		i_pwr_mode <= 2'h0;
		repeat (8) @(posedge i_mclk);
	endtask : t_lf_auto

	task t_lf_masked;
		wr(OFF_MASK, 32'h0);
		wr(OFF_CTRL, 32'h81);
		lf_stop <= 1'b1;
		repeat (40) @(posedge i_mclk);
		@(negedge i_mclk);
		chk(o_irq, 1'b0);
		chk(o_lf_src_int, 1'b0);
		rd(OFF_STATUS);
		chk(rd_val, 32'h1);
		// Shutdown stops the watcher, so the live failure drops although the crystal is dead
		@(posedge i_mclk);
		i_pwr_mode <= 2'h3;
		repeat (4) @(posedge i_mclk);
		i_pwr_mode <= 2'h0;
		@(negedge i_mclk);
		rd(OFF_STATE);
		chk(rd_val[7], 1'b0);
		lf_stop <= 1'b0;
		repeat (8) @(posedge i_mclk);
	endtask : t_lf_masked

	task t_hf;
		for (int s = 1; s < 4; s++) begin
			wr(OFF_CTRL, 32'h8C | 32'(s << 4));
			wr(OFF_MASK, 32'hF);
			chk(o_sys_src, 32'(s));
			hf_stop <= 3'(1 << (s - 1));
			wait_irq();
			chk(o_irq, 1'b1);
			chk(o_sys_src, 32'h0);
			rd(OFF_STATUS);
			chk(rd_val, 32'(1 << s));
			hf_stop <= 3'h0;
		end
	endtask : t_hf

	task t_hf_quiet;
		wr(OFF_CTRL, 32'h98);
		hf_stop <= 3'h1;
		repeat (40) @(posedge i_mclk);
		@(negedge i_mclk);
		chk(o_sys_src, 32'h0);
		chk(o_irq, 1'b0);
		rd(OFF_STATUS);
		chk(rd_val, 32'h0);
		hf_stop <= 3'h0;
	endtask : t_hf_quiet

	task t_rate;
		wr(OFF_CTRL, 32'hC0);
		@(negedge i_mclk);
		chk(o_high_freq_crystal_clock_16m, 1'b1);
		rd(OFF_STATE);
		chk(rd_val, 32'h08);
		wr(OFF_CTRL, 32'h80);
		@(negedge i_mclk);
		chk(o_high_freq_crystal_clock_16m, 1'b0);
	endtask : t_rate

	initial begin
		i_nrst      = 1'b0;
		i_wr        = 1'b0;
		i_rd        = 1'b0;
		i_addr      = 4'h0;
		i_wdata     = 32'h0;
		i_pwr_mode  = 2'h0;
		lf_stop     = 1'b0;
		hf_stop     = 3'h0;
		failures    = 0;
		check_count = 0;
		cycles      = 0;
		repeat (16) @(posedge i_mclk);
		i_nrst <= 1'b1;
		@(posedge i_mclk);
		t_reset();
		t_lf_auto();
		t_lf_masked();
		t_hf();
		t_hf_quiet();
		t_rate();
		give_verdict();
	end
endmodule : clock_fail_monitor_tb
`default_nettype wire
